// >>> design/aea_pkg.sv
/*
 * Constants of the active energy accumulator: register offsets, field
 * positions, reset values, thresholds and timing counts.
 * Assumes a 50 MHz metering master clock and 24-bit filtered power samples.
 */
package aea_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENERGY       = 8'h01;
    localparam logic [7:0] OFS_ENERGY_CLEAR = 8'h02;
    localparam logic [7:0] OFS_WAVE_SEL     = 8'h0D;
    localparam logic [7:0] OFS_CREEP_CFG    = 8'h0E;
    localparam logic [7:0] OFS_ACCUM_CFG    = 8'h0F;
    localparam logic [7:0] OFS_GAIN         = 8'h1D;
    localparam logic [7:0] OFS_OFFSET       = 8'h20;
    localparam logic [7:0] OFS_DIVISOR      = 8'h24;
    localparam logic [7:0] OFS_IRQ_EN_LOW   = 8'hD9;
    localparam logic [7:0] OFS_IRQ_EN_HIGH  = 8'hDB;
    localparam logic [7:0] OFS_IRQ_ST_LOW   = 8'hDC;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ACC_ABS_BIT      = 0;
    localparam int ACC_POS_BIT      = 1;
    localparam int ACC_DIR_BIT      = 4;
    localparam int IRQ_CREEP_BIT    = 0;
    localparam int IRQ_SIGN_BIT     = 3;
    localparam int IRQ_WAVE_EN_BIT  = 5;
    localparam int WAVE_SRC_LSB     = 0;
    localparam int WAVE_RATE_LSB    = 5;
    localparam logic [2:0] WAVE_SRC_ACTIVE = 3'h0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_CFG8    = 8'h00;
    localparam logic [11:0] RST_GAIN    = 12'h000;
    localparam logic [15:0] RST_OFFSET  = 16'h0000;
    localparam logic [7:0]  RST_STATUS  = 8'h00;

    // ------------------------------------------------------------------
    // Arithmetic shape
    // ------------------------------------------------------------------
    localparam int ACC_W      = 49;
    localparam int READ_W     = 24;
    localparam int GAIN_SHIFT = 12;
    localparam int OFS_FRAC   = 8;
    localparam int FULL_SCALE = 838861;
    // Creep thresholds in millionths of a percent, then in sample LSBs.
    localparam int CREEP_PPM1 = 15000;
    localparam int CREEP_PPM2 = 7500;
    localparam int CREEP_PPM3 = 3700;
    // One percent of full scale is taken first so the product stays inside 32 bits.
    localparam int CREEP_THR1 = FULL_SCALE / 100 * CREEP_PPM1 / 1000000;
    localparam int CREEP_THR2 = FULL_SCALE / 100 * CREEP_PPM2 / 1000000;
    localparam int CREEP_THR3 = FULL_SCALE / 100 * CREEP_PPM3 / 1000000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ      = 50000000;
    localparam logic [2:0]  STEP_LAST   = 3'h4;
    localparam int          WAVE_SPS0   = 25600;
    localparam int          WAVE_SPS1   = 12800;
    localparam int          WAVE_SPS2   = 6400;
    localparam int          WAVE_SPS3   = 3200;
    localparam logic [15:0] WAVE_CYC0   = 16'(CLK_HZ / WAVE_SPS0);
    localparam logic [15:0] WAVE_CYC1   = 16'(CLK_HZ / WAVE_SPS1);
    localparam logic [15:0] WAVE_CYC2   = 16'(CLK_HZ / WAVE_SPS2);
    localparam logic [15:0] WAVE_CYC3   = 16'(CLK_HZ / WAVE_SPS3);

endpackage

// >>> design/aea_core.sv
/*
 * Active energy accumulator: gain and offset correction of the filtered
 * active power, sign change and creep detection, divided accumulation into
 * a 49-bit energy register, waveform samples and the register port.
 * Assumes power_i is a synchronous signed sample held valid on every clock.
 */
// What this block does
// - Adds a 16-bit signed offset correction to the filtered power.
// - An offset of 256 equals one power sample LSB.
// - Sign change of power sets status bit 3 in chosen direction.
// - Direction bit clear: only positive-to-negative transitions set the flag.
// - Direction bit set: only negative-to-positive transitions set the flag.
// - Enabled sign flag raises the interrupt until software clears the flag.
// - Samples below the creep threshold are not accumulated.
// - Below threshold sets status bit 0; enabled, it raises the interrupt.
// - Threshold field 00 off; 01, 10, 11 pick three thresholds.
// - Energy kept in a 49-bit signed accumulator; readout shows upper 24 bits.
// - One accumulation step every five master clock cycles.
// - Both mode bits clear: signed accumulation, negative power subtracts.
// - Both mode bits set behaves as positive-only.
// - Positive-only mode discards negative samples.
// - Absolute mode adds the magnitude of each sample.
// - Power divided by 8-bit divisor first; zero divides by one.
// - Clear readout returns the energy and clears the upper 24 bits.
// - Active power waveform samples at 25.6, 12.8, 6.4 or 3.2 kSPS.
// - Energy readout wraps around in both directions and keeps counting.
// - Power is scaled by one plus 12-bit signed gain over 4096.
`timescale 1ns/1ps

module aea_core
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [23:0] power_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [23:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [23:0] rd_data_o,
    output logic             irq_o,
    output logic      [23:0] wave_data_o,
    output logic             wave_valid_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  step;
        logic [48:0] acc;
        logic [15:0] offset;
        logic [11:0] gain;
        logic [7:0]  divisor;
        logic [7:0]  accum_cfg;
        logic [7:0]  creep_cfg;
        logic [7:0]  wave_cfg;
        logic [7:0]  irq_en_low;
        logic [7:0]  irq_en_high;
        logic [7:0]  irq_st_low;
        logic        sign_prev;
        logic        sign_seen;
        logic [15:0] wave_cnt;
        logic [23:0] wave_data;
        logic        wave_valid;
        logic        irq;
        logic [23:0] rd_data;
    } aea_state_t;

    aea_state_t         st_reg;
    aea_state_t         st_next;
    logic signed [35:0] corr;
    logic        [35:0] mag;
    logic        [35:0] quot;
    logic signed [35:0] add;
    logic               below;
    logic               step_now;
    logic               clear_rd;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Computes the corrected power, the accumulation step and register access.
    always_comb
    begin
        logic signed [35:0] prod;
        logic signed [35:0] gained;
        logic        [35:0] thr;
        logic        [7:0]  div_eff;
        logic        [48:0] sum;
        logic        [7:0]  st_set;
        logic        [15:0] wave_lim;
        prod     = 36'sh0;
        gained   = 36'sh0;
        thr      = 36'h0;
        div_eff  = 8'h01;
        sum      = 49'h0;
        st_set   = 8'h00;
        wave_lim = aea_pkg::WAVE_CYC0;
        st_next  = st_reg;

        // Gain scaling is one plus gain over 4096.
        prod   = 36'($signed(power_i) * $signed(st_reg.gain));
        gained = 36'($signed(power_i)) + (prod >>> aea_pkg::GAIN_SHIFT);
        // Power is carried with 8 fractional bits so one offset LSB is 1/256.
        corr = (gained <<< aea_pkg::OFS_FRAC)
             + 36'($signed(st_reg.offset));
        mag  = corr[35] ? 36'(-corr) : 36'(corr);

        // Creep threshold chosen by the two-bit field.
        unique case (st_reg.creep_cfg[1:0])
            2'h1: thr = 36'(aea_pkg::CREEP_THR1) << aea_pkg::OFS_FRAC;
            2'h2: thr = 36'(aea_pkg::CREEP_THR2) << aea_pkg::OFS_FRAC;
            2'h3: thr = 36'(aea_pkg::CREEP_THR3) << aea_pkg::OFS_FRAC;
            2'h0: thr = 36'h0;
        endcase
        below = (st_reg.creep_cfg[1:0] != 2'h0) && (mag < thr);

        // Divisor of zero counts as one.
        div_eff = (st_reg.divisor == 8'h00) ? 8'h01 : st_reg.divisor;
        quot    = mag / {28'h0, div_eff};

        // Mode selection; positive-only wins when both bits are set.
        if (below)
        begin
            add = 36'sh0;
        end
        else if (st_reg.accum_cfg[aea_pkg::ACC_POS_BIT])
        begin
            add = corr[35] ? 36'sh0 : $signed(quot);
        end
        else if (st_reg.accum_cfg[aea_pkg::ACC_ABS_BIT])
        begin
            add = $signed(quot);
        end
        else
        begin
            add = corr[35] ? 36'(-$signed(quot)) : $signed(quot);
        end

        // The 49-bit sum wraps naturally in both directions.
        step_now = (st_reg.step == aea_pkg::STEP_LAST);
        sum      = st_reg.acc + {{13{add[35]}}, add};
        st_next.step = step_now ? 3'h0 : 3'(st_reg.step + 3'h1);
        if (step_now)
        begin
            st_next.acc       = sum;
            st_next.sign_prev = corr[35];
            st_next.sign_seen = 1'b1;
            if (st_reg.sign_seen && (st_reg.sign_prev != corr[35]))
            begin
                if (!st_reg.accum_cfg[aea_pkg::ACC_DIR_BIT] && corr[35])
                begin
                    st_set[aea_pkg::IRQ_SIGN_BIT] = 1'b1;
                end
                if (st_reg.accum_cfg[aea_pkg::ACC_DIR_BIT] && !corr[35])
                begin
                    st_set[aea_pkg::IRQ_SIGN_BIT] = 1'b1;
                end
            end
            if (below)
            begin
                st_set[aea_pkg::IRQ_CREEP_BIT] = 1'b1;
            end
        end

        // Register reads; data stands in the following cycle only.
        clear_rd = rd_i && (addr_i == aea_pkg::OFS_ENERGY_CLEAR);
        st_next.rd_data = 24'h0;
        if (rd_i)
        begin
            case (addr_i)
                aea_pkg::OFS_ENERGY:       st_next.rd_data = st_reg.acc[48:25];
                aea_pkg::OFS_ENERGY_CLEAR: st_next.rd_data = st_reg.acc[48:25];
                aea_pkg::OFS_WAVE_SEL:     st_next.rd_data = {16'h0, st_reg.wave_cfg};
                aea_pkg::OFS_CREEP_CFG:    st_next.rd_data = {16'h0, st_reg.creep_cfg};
                aea_pkg::OFS_ACCUM_CFG:    st_next.rd_data = {16'h0, st_reg.accum_cfg};
                aea_pkg::OFS_GAIN:         st_next.rd_data = {12'h0, st_reg.gain};
                aea_pkg::OFS_OFFSET:       st_next.rd_data = {8'h0, st_reg.offset};
                aea_pkg::OFS_DIVISOR:      st_next.rd_data = {16'h0, st_reg.divisor};
                aea_pkg::OFS_IRQ_EN_LOW:   st_next.rd_data = {16'h0, st_reg.irq_en_low};
                aea_pkg::OFS_IRQ_EN_HIGH:  st_next.rd_data = {16'h0, st_reg.irq_en_high};
                aea_pkg::OFS_IRQ_ST_LOW:   st_next.rd_data = {16'h0, st_reg.irq_st_low};
                default:                   st_next.rd_data = 24'h0;
            endcase
        end
        // Clearing subtracts the old upper part so a same-cycle step is kept.
        if (clear_rd)
        begin
            st_next.acc = st_next.acc - {st_reg.acc[48:25], 25'h0};
        end

        // Register writes; status bits are cleared by writing ones.
        st_next.irq_st_low = st_reg.irq_st_low;
        if (wr_i)
        begin
            case (addr_i)
                aea_pkg::OFS_WAVE_SEL:    st_next.wave_cfg    = wr_data_i[7:0];
                aea_pkg::OFS_CREEP_CFG:   st_next.creep_cfg   = wr_data_i[7:0];
                aea_pkg::OFS_ACCUM_CFG:   st_next.accum_cfg   = wr_data_i[7:0];
                aea_pkg::OFS_GAIN:        st_next.gain        = wr_data_i[11:0];
                aea_pkg::OFS_OFFSET:      st_next.offset      = wr_data_i[15:0];
                aea_pkg::OFS_DIVISOR:     st_next.divisor     = wr_data_i[7:0];
                aea_pkg::OFS_IRQ_EN_LOW:  st_next.irq_en_low  = wr_data_i[7:0];
                aea_pkg::OFS_IRQ_EN_HIGH: st_next.irq_en_high = wr_data_i[7:0];
                aea_pkg::OFS_IRQ_ST_LOW:  st_next.irq_st_low  = st_reg.irq_st_low
                                                              & ~wr_data_i[7:0];
                default:                  st_next.irq_st_low  = st_reg.irq_st_low;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        st_next.irq_st_low = st_next.irq_st_low | st_set;

        // Interrupt level follows enabled status bits.
        st_next.irq = |(st_next.irq_st_low & st_next.irq_en_low);

        // Waveform sample timer and active power sample output.
        unique case (st_reg.wave_cfg[aea_pkg::WAVE_RATE_LSB +: 2])
            2'h0: wave_lim = aea_pkg::WAVE_CYC0;
            2'h1: wave_lim = aea_pkg::WAVE_CYC1;
            2'h2: wave_lim = aea_pkg::WAVE_CYC2;
            2'h3: wave_lim = aea_pkg::WAVE_CYC3;
        endcase
        st_next.wave_valid = 1'b0;
        if (st_reg.wave_cnt >= 16'(wave_lim - 16'h1))
        begin
            st_next.wave_cnt = 16'h0;
            if (st_reg.irq_en_high[aea_pkg::IRQ_WAVE_EN_BIT]
                && st_reg.wave_cfg[aea_pkg::WAVE_SRC_LSB +: 3] == aea_pkg::WAVE_SRC_ACTIVE)
            begin
                st_next.wave_valid = 1'b1;
                st_next.wave_data  = corr[31:8];
            end
        end
        else
        begin
            st_next.wave_cnt = 16'(st_reg.wave_cnt + 16'h1);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Registers the whole state; reset loads constants only.
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg             <= '0;
            st_reg.offset      <= aea_pkg::RST_OFFSET;
            st_reg.gain        <= aea_pkg::RST_GAIN;
            st_reg.divisor     <= aea_pkg::RST_CFG8;
            st_reg.accum_cfg   <= aea_pkg::RST_CFG8;
            st_reg.creep_cfg   <= aea_pkg::RST_CFG8;
            st_reg.wave_cfg    <= aea_pkg::RST_CFG8;
            st_reg.irq_en_low  <= aea_pkg::RST_CFG8;
            st_reg.irq_en_high <= aea_pkg::RST_CFG8;
            st_reg.irq_st_low  <= aea_pkg::RST_STATUS;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign rd_data_o    = st_reg.rd_data;
    assign irq_o        = st_reg.irq;
    assign wave_data_o  = st_reg.wave_data;
    assign wave_valid_o = st_reg.wave_valid;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    // Step counter cycles through five states.
    step_period_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (st_reg.step == aea_pkg::STEP_LAST) |=> (st_reg.step == 3'h0) ##4
        (st_reg.step == aea_pkg::STEP_LAST))
        else $error("accumulation step period is not five cycles");

    // Enabled sign flag drives the interrupt.
    sign_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (st_reg.irq_st_low[aea_pkg::IRQ_SIGN_BIT] && st_reg.irq_en_low[aea_pkg::IRQ_SIGN_BIT]
         && !wr_i) |=> irq_o)
        else $error("sign change interrupt not asserted");

    // The creep status flag holds unless cleared by a write.
    sticky_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (st_reg.irq_st_low[aea_pkg::IRQ_CREEP_BIT] && !wr_i)
        |=> st_reg.irq_st_low[aea_pkg::IRQ_CREEP_BIT])
        else $error("creep flag dropped without a clear");

    // Energy read returns the upper 24 bits.
    energy_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (rd_i && addr_i == aea_pkg::OFS_ENERGY) |=> (rd_data_o == $past(st_reg.acc[48:25])))
        else $error("energy readout mismatch");

    // Clearing read returns the energy and empties the upper bits.
    clear_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (clear_rd && !step_now) |=> (rd_data_o == $past(st_reg.acc[48:25]))
        && (st_reg.acc[48:25] == 24'h0))
        else $error("clearing energy read misbehaved");

    // Creep samples leave the energy untouched.
    creep_skip_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (step_now && below && !clear_rd) |=> $stable(st_reg.acc))
        else $error("energy accumulated below creep threshold");

    // Positive-only mode ignores negative samples.
    pos_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (step_now && st_reg.accum_cfg[aea_pkg::ACC_POS_BIT] && corr[35] && !clear_rd)
        |=> $stable(st_reg.acc))
        else $error("negative sample accumulated in positive-only mode");

    // Signed mode adds the divided sample with its sign.
    signed_acc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (step_now && st_reg.accum_cfg[1:0] == 2'h0 && !below && !clear_rd)
        |=> (st_reg.acc == 49'($past(st_reg.acc) + {{13{$past(add[35])}}, $past(add)})))
        else $error("signed accumulation mismatch");

    // Default direction flags a positive-to-negative change.
    sign_dir_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (step_now && st_reg.sign_seen && !st_reg.sign_prev && corr[35]
         && !st_reg.accum_cfg[aea_pkg::ACC_DIR_BIT])
        |=> st_reg.irq_st_low[aea_pkg::IRQ_SIGN_BIT])
        else $error("sign change flag not set");

endmodule // aea_core

// >>> verif/aea_power_src.sv
/*
 * Source of the filtered active power samples seen by the accumulator.
 * Assumes the bench picks the level and the clock is the master clock.
 */
`timescale 1ns/1ps

module aea_power_src
(
    input  wire logic        mclk_i,
    input  wire logic [23:0] level_i,
    output logic      [23:0] power_o
);
    // The upstream filter delivers a new sample on every clock.
    always_ff @(posedge mclk_i)
    begin
        power_o <= level_i;
    end
endmodule // aea_power_src

// >>> verif/tb_top.sv
/*
 * Self-checking bench of the active energy accumulator.
 * Assumes the register port of the core and a fixed random seed.
 */
`timescale 1ns/1ps

module tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [23:0] level = 24'h000000;
    logic [23:0] power;
    logic [7:0]  addr = 8'h00;
    logic [23:0] wdat = 24'h000000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [23:0] rdat;
    logic        irq;
    logic [23:0] wave;
    logic        wvld;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;

    aea_power_src i_src (.mclk_i(mclk_i), .level_i(level), .power_o(power));
    aea_core i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .power_i(power), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .irq_o(irq),
        .wave_data_o(wave), .wave_valid_o(wvld));

    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    initial
    begin
        forever #10 mclk_i = ~mclk_i;
    end

    // A hang is cut short by a cycle ceiling.
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [23:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [23:0] d);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 d = rdat;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [23:0] exp);
        logic [23:0] d;
        rreg(a, d);
        chk(d, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // Energy gained over exactly ten accumulation steps.
    task automatic delta10(output logic [23:0] dl);
        logic [23:0] a;
        logic [23:0] b;
        rreg(aea_pkg::OFS_ENERGY, a);
        idle(48);
        rreg(aea_pkg::OFS_ENERGY, b);
        dl = b - a;
    endtask

    function automatic logic [23:0] exp_delta(int mode, bit neg, int m);
        int v;
        v = neg ? -m : m;
        if (mode >= 2 && neg)
            v = 0;
        else if (mode == 1)
            v = m;
        return 24'(10 * v);
    endfunction

    // Creep threshold in sample LSBs for a threshold field value.
    function automatic int creep_thr(int c);
        return (c == 1) ? aea_pkg::CREEP_THR1
             : (c == 2) ? aea_pkg::CREEP_THR2 : aea_pkg::CREEP_THR3;
    endfunction

    task automatic wait_pulse(output int n);
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1 n++;
        end while (wvld !== 1'b1 && n < 20000);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [7:0]  ad [7] = '{8'h0E, 8'h0F, 8'h1D, 8'h20, 8'h24, 8'hD9, 8'hDB};
        logic [23:0] mk [7] = '{24'hFF, 24'hFF, 24'hFFF, 24'hFFFF, 24'hFF, 24'hFF, 24'hFF};
        logic [23:0] v;
        logic [23:0] dl;
        int          m;
        int          dv;
        int          n;
        void'($urandom(90357));
        idle(16);
        chk(rdat | wave | 24'({irq, wvld}), 24'h000000);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++)
            rchk(ad[i], 24'h000000);
        wreg(8'h55, 24'hABCDEF);
        rchk(8'h55, 24'h000000);
        for (int i = 0; i < 7; i++)
        begin
            v = $urandom & mk[i];
            wreg(ad[i], v);
            rchk(ad[i], v);
            wreg(ad[i], 24'h000000);
        end
        $display("test registers done");
        for (int md = 0; md < 4; md++)
            for (int s = 0; s < 2; s++)
            begin
                m = 1 + $urandom % 8;
                dv = $urandom % 5;
                wreg(aea_pkg::OFS_ACCUM_CFG, 24'(md));
                wreg(aea_pkg::OFS_DIVISOR, 24'(dv));
                level <= 24'((s ? -1 : 1) * 131072 * (dv == 0 ? 1 : dv) * m);
                idle(10);
                delta10(dl);
                chk(dl, exp_delta(md, s, m));
            end
        $display("test modes done");
        level <= 24'h000000;
        idle(10);
        rreg(aea_pkg::OFS_ENERGY, v);
        rchk(aea_pkg::OFS_ENERGY_CLEAR, v);
        rchk(aea_pkg::OFS_ENERGY, 24'h000000);
        wreg(aea_pkg::OFS_ACCUM_CFG, 24'h000000);
        wreg(aea_pkg::OFS_DIVISOR, 24'h000001);
        level <= 24'hFE0000;
        idle(2);
        rreg(aea_pkg::OFS_ENERGY, v);
        idle(48);
        rchk(aea_pkg::OFS_ENERGY, v - 24'h00000A);
        $display("test clear and wrap done");
        wreg(aea_pkg::OFS_IRQ_EN_LOW, 24'h000008);
        for (int dr = 0; dr < 2; dr++)
            for (int t = 0; t < 2; t++)
            begin
                wreg(aea_pkg::OFS_ACCUM_CFG, 24'(dr << 4));
                level <= t ? 24'hFE0000 : 24'h020000;
                idle(20);
                wreg(aea_pkg::OFS_IRQ_ST_LOW, 24'h0000FF);
                idle(5);
                level <= t ? 24'h020000 : 24'hFE0000;
                idle(20);
                rchk(aea_pkg::OFS_IRQ_ST_LOW, (t == dr) ? 24'h08 : 24'h00);
                chk(24'(irq), 24'(t == dr));
                wreg(aea_pkg::OFS_IRQ_ST_LOW, 24'h000008);
                idle(3);
                chk(24'(irq), 24'h000000);
            end
        $display("test sign done");
        wreg(aea_pkg::OFS_ACCUM_CFG, 24'h000000);
        wreg(aea_pkg::OFS_IRQ_EN_LOW, 24'h000001);
        for (int c = 1; c < 4; c++)
        begin
            wreg(aea_pkg::OFS_CREEP_CFG, 24'(c));
            level <= 24'(creep_thr(c) - 1);
            idle(20);
            delta10(dl);
            chk(dl, 24'h000000);
            rchk(aea_pkg::OFS_IRQ_ST_LOW, 24'h000001);
            chk(24'(irq), 24'h000001);
            level <= 24'(creep_thr(c));
            idle(20);
            rchk(aea_pkg::OFS_IRQ_ST_LOW, 24'h000001);
            wreg(aea_pkg::OFS_IRQ_ST_LOW, 24'h0000FF);
            idle(10);
            rchk(aea_pkg::OFS_IRQ_ST_LOW, 24'h000000);
            chk(24'(irq), 24'h000000);
        end
        $display("test creep done");
        m = 4096 * (1 + $urandom % 8);
        level <= 24'(m);
        wreg(aea_pkg::OFS_GAIN, 24'h0007FF);
        wreg(aea_pkg::OFS_OFFSET, 24'h000300);
        wreg(aea_pkg::OFS_IRQ_EN_HIGH, 24'h000020);
        for (int r = 0; r < 4; r++)
        begin
            wreg(aea_pkg::OFS_WAVE_SEL, 24'(r << 5));
            wait_pulse(n);
            wait_pulse(n);
            chk(24'(n), 24'(50000000 / (25600 >> r)));
            chk(wave, 24'(m + m / 4096 * 2047 + 3));
        end
        $display("test waveform done");
        tally_and_finish();
    end
endmodule // tb_top
